// ==== logic/alarm_panel.sv ====
// Two process alarms with a push-button threshold menu and AHB-Lite registers.
// Assumes DISP_VALUE is BCD from logic on CLK_SYS; buttons come from pins.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module alarm_panel import alarm_pkg::*; #(
   parameter int TICK_LEN = TICK_CYCLES
) (
   // Clock, reset, enable
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic CE,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   // Measurement path
   input wire bcd_t DISP_VALUE,
   // Front panel buttons, active high
   input wire btn_t BTN,
   // Switch outputs, high means closed
   output logic [1:0] ALARM_SW,
   // Display side
   output logic [1:0] ALARM_IND,
   output logic SHOW_ALARM_ID,
   output var menu_t MENU_STATE,
   output var bcd_t EDIT_VALUE,
   output logic [1:0] EDIT_DIGIT,
   output logic DIGIT_FLASH,
   output logic SP_SEL
);
   // ==========================================================
   // State
   typedef struct packed {
      btn_t s1;
      btn_t s2;
      btn_t s3;
      btn_t lvl;
      logic [TICK_W-1:0] tcnt;
      logic tick;
      logic phase;
      logic [3:0] idle;
      menu_t menu;
      logic sel;
      logic [1:0] dig;
      bcd_t ebuf;
      logic access;
      bcd_t pin;
      alm_cfg_t [1:0] cfg;
      logic dph;
      logic a_wr;
      logic a_hit;
      logic [7:0] a_addr;
      logic ready;
      logic [31:0] rdata;
      logic accept;
      logic [1:0] sw;
      logic [1:0] ind;
      logic show_id;
      logic flash;
   } state_t;
   state_t q, d;
   logic [13:0] val_bin;
   logic [1:0] a_act, a_alarm;
   btn_t pr;
   logic [31:0] rd;
   logic take;
   // Display value seen as binary by both channels
   assign val_bin = bcd2bin(DISP_VALUE);
   // ==========================================================
   // Alarm channels
   for (genvar i = 0; i < 2; i++) begin : g_alm
      alarm_channel u_chan (
         .clk(CLK_SYS),
         .rst_b(RST_B),
         .ce(CE),
         .tick(q.tick),
         .accept(q.accept),
         .cfg(q.cfg[i]),
         .value(val_bin),
         .active(a_act[i]),
         .alarm(a_alarm[i])
      );
   end
   // ==========================================================
   // Next state
   always_comb begin
      d = q;
      pr = '0;
      rd = '0;
      take = 1'b0;
      // Buttons: three stages, a change counts when stages two and three agree
      d.s1 = BTN;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
      pr = d.lvl & ~q.lvl;
      // One second tick shared by every timer
      d.tick = 1'b0;
      if (q.tcnt == TICK_W'(TICK_LEN - 1)) begin
         d.tcnt = '0;
         d.tick = 1'b1;
      end else begin
         d.tcnt = q.tcnt + 1'b1;
      end
      if (q.tick) d.phase = ~q.phase;
      // --------------------------------------------------------
      // Bus data phase: one wait state, then the answer
      if (q.dph) begin
         d.dph = 1'b0;
         d.ready = 1'b1;
         if (q.a_wr && q.a_hit) begin
            unique case (q.a_addr)
               A_CTRL: begin
                  d.access = HWDATA[CTRL_ACC];
                  for (int i = 0; i < 2; i++) begin
                     d.cfg[i].en = HWDATA[CTRL_EN + i];
                     d.cfg[i].high = HWDATA[CTRL_HI + i];
                     d.cfg[i].closed = HWDATA[CTRL_NC + i];
                  end
               end
               A_PIN: d.pin = HWDATA[15:0];
               default: begin
                  for (int i = 0; i < 2; i++) begin
                     if (q.a_addr[7:4] == 4'(i + 1)) begin
                        case (q.a_addr[3:0])
                           O_THR: d.cfg[i].thr = HWDATA[15:0];
                           O_HYST: d.cfg[i].hyst = HWDATA[15:0];
                           O_DLY: d.cfg[i].dly = HWDATA[15:0];
                           O_MUTE: d.cfg[i].mute = HWDATA[15:0];
                           default: d.cfg[i].thr = q.cfg[i].thr;
                        endcase
                     end
                  end
               end
            endcase
         end else if (q.a_hit) begin
            unique case (q.a_addr)
               A_CTRL: begin
                  rd[CTRL_ACC] = q.access;
                  for (int i = 0; i < 2; i++) begin
                     rd[CTRL_EN + i] = q.cfg[i].en;
                     rd[CTRL_HI + i] = q.cfg[i].high;
                     rd[CTRL_NC + i] = q.cfg[i].closed;
                  end
               end
               A_PIN: rd[15:0] = q.pin;
               A_STAT: begin
                  rd[STAT_IND +: 2] = q.ind;
                  rd[STAT_SW +: 2] = q.sw;
                  rd[STAT_ACC] = q.access;
                  rd[STAT_MENU +: 3] = q.menu;
               end
               default: begin
                  for (int i = 0; i < 2; i++) begin
                     if (q.a_addr[7:4] == 4'(i + 1)) begin
                        case (q.a_addr[3:0])
                           O_THR: rd[15:0] = q.cfg[i].thr;
                           O_HYST: rd[15:0] = q.cfg[i].hyst;
                           O_DLY: rd[15:0] = q.cfg[i].dly;
                           O_MUTE: rd[15:0] = q.cfg[i].mute;
                           default: rd = '0;
                        endcase
                     end
                  end
               end
            endcase
         end
         d.rdata = rd; // Unmapped reads answer zero
      end
      // Address phase taken while the bus is ready
      take = HSEL && HTRANS[1] && HREADY;
      if (take) begin
         d.dph = 1'b1;
         d.ready = 1'b0;
         d.a_wr = HWRITE;
         d.a_hit = (HADDR[31:8] == 24'h00_0000);
         d.a_addr = HADDR[7:0];
      end
      // --------------------------------------------------------
      // Inactivity seconds, cleared by any press
      if (|pr) begin
         d.idle = '0;
      end else if (q.tick && q.menu != M_DISP) begin
         d.idle = q.idle + 4'h1;
      end
      // Operator menu; it only ever reaches the two thresholds
      d.accept = 1'b0;
      unique case (q.menu)
         M_DISP: begin
            d.idle = '0;
            if ((pr.p && d.lvl.up) || (pr.up && d.lvl.p)) begin
               if (q.access) begin
                  d.sel = 1'b0;
                  d.dig = '0;
                  if (q.pin == '0) d.menu = M_SP;
                  else d.menu = M_CODE;
               end
            end else if (pr.p) begin
               d.accept = 1'b1;
            end
         end
         M_CODE: begin
            if (pr.p) begin
               d.menu = M_CODE_ED;
               d.ebuf = '0;
               d.dig = '0;
            end else if (pr.ex) begin
               d.menu = M_DISP;
            end
         end
         M_CODE_ED: begin
            if (pr.up) d.ebuf = digit_step(q.ebuf, q.dig, 1'b1);
            else if (pr.dn) d.ebuf = digit_step(q.ebuf, q.dig, 1'b0);
            else if (pr.p) d.dig = q.dig + 2'h1;
            else if (pr.ex) begin
               if (q.ebuf == q.pin) begin
                  d.menu = M_SP;
                  d.sel = 1'b0;
               end else begin
                  d.menu = M_DISP;
               end
            end
         end
         M_SP: begin
            if (pr.up || pr.dn) begin
               d.sel = ~q.sel;
            end else if (pr.p) begin
               d.menu = M_SP_ED;
               d.ebuf = q.cfg[q.sel].thr;
               d.dig = '0;
            end else if (pr.ex) begin
               d.menu = M_DISP;
            end
         end
         M_SP_ED: begin
            if (pr.up) d.ebuf = digit_step(q.ebuf, q.dig, 1'b1);
            else if (pr.dn) d.ebuf = digit_step(q.ebuf, q.dig, 1'b0);
            else if (pr.p) d.dig = q.dig + 2'h1;
            else if (pr.ex) begin
               d.cfg[q.sel].thr = q.ebuf;
               d.menu = M_SP;
            end
         end
      endcase
      // Leave the menu after ten quiet seconds
      if (q.menu != M_DISP && q.idle == IDLE_S) begin
         d.menu = M_DISP;
      end
      // --------------------------------------------------------
      // Registered outputs
      for (int i = 0; i < 2; i++) begin
         d.sw[i] = a_alarm[i] ? q.cfg[i].closed : ~q.cfg[i].closed;
      end
      d.ind = a_act;
      d.show_id = q.phase & (|a_act);
      d.flash = q.phase & (d.menu == M_CODE_ED || d.menu == M_SP_ED);
   end
   // ==========================================================
   // State register; power-on: access off, passcode zero
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         q <= '0;
         q.ready <= 1'b1;
      end else if (CE) begin
         q <= d;
      end
   end
   // ==========================================================
   // Outputs straight from the state register; HRESP tied low
   assign HREADYOUT = q.ready;
   assign HRDATA = q.rdata;
   assign HRESP = 1'b0; // Always OKAY
   assign ALARM_SW = q.sw;
   assign ALARM_IND = q.ind;
   assign SHOW_ALARM_ID = q.show_id;
   assign MENU_STATE = q.menu;
   assign EDIT_VALUE = q.ebuf;
   assign EDIT_DIGIT = q.dig;
   assign DIGIT_FLASH = q.flash;
   assign SP_SEL = q.sel;
endmodule : alarm_panel
`default_nettype wire

// ==== logic/alarm_pkg.sv ====
// Constants, types and helpers shared by the dual process alarm block.
// Assumes a 20 MHz system clock and four digit BCD display values.
package alarm_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_S = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_S;
   localparam int TICK_W = 25;
   localparam logic [3:0] IDLE_S = 4'hA;
   localparam logic [13:0] MAX_S = 14'h0E10;
   // ==========================================================
   // Register map (byte addresses, low byte only)
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PIN = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [3:0] O_THR = 4'h0;
   localparam logic [3:0] O_HYST = 4'h4;
   localparam logic [3:0] O_DLY = 4'h8;
   localparam logic [3:0] O_MUTE = 4'hC;
   // Control and status bit positions
   localparam int CTRL_ACC = 0;
   localparam int CTRL_EN = 1;
   localparam int CTRL_HI = 3;
   localparam int CTRL_NC = 5;
   localparam int STAT_IND = 0;
   localparam int STAT_SW = 2;
   localparam int STAT_ACC = 4;
   localparam int STAT_MENU = 8;
   // ==========================================================
   // Types
   typedef logic [15:0] bcd_t;
   typedef struct packed {
      logic p;
      logic up;
      logic dn;
      logic ex;
   } btn_t;
   typedef struct packed {
      logic en;
      logic high;
      logic closed;
      bcd_t thr;
      bcd_t hyst;
      bcd_t dly;
      bcd_t mute;
   } alm_cfg_t;
   typedef enum logic [2:0] {M_DISP, M_CODE, M_CODE_ED, M_SP, M_SP_ED} menu_t;
   // ==========================================================
   // Four BCD digits to binary
   function automatic logic [13:0] bcd2bin(input bcd_t v);
      return 14'(v[15:12]) * 14'h03E8 + 14'(v[11:8]) * 14'h0064
         + 14'(v[7:4]) * 14'h000A + 14'(v[3:0]);
   endfunction : bcd2bin
   // Seconds setting, clamped to the longest allowed time
   function automatic logic [11:0] sec_of(input bcd_t v);
      logic [13:0] b;
      b = bcd2bin(v);
      return (b > MAX_S) ? MAX_S[11:0] : b[11:0];
   endfunction : sec_of
   // One decimal digit up or down, wrapping 9 <-> 0; digit 0 is leftmost
   function automatic bcd_t digit_step(input bcd_t v, input logic [1:0] d,
                                       input logic up);
      int s;
      logic [3:0] n;
      bcd_t r;
      s = 4 * (3 - int'(d));
      n = v[s +: 4];
      if (up) begin
         n = (n == 4'h9) ? 4'h0 : n + 4'h1;
      end else begin
         n = (n == 4'h0) ? 4'h9 : n - 4'h1;
      end
      r = v;
      r[s +: 4] = n;
      return r;
   endfunction : digit_step
endpackage : alarm_pkg

// ==== logic/alarm_channel.sv ====
// One alarm channel: hysteresis compare, activation wait and mute timer.
// Assumes a one cycle second tick and accept pulse from the panel logic.
`timescale 1ns/10ps
`default_nettype none
module alarm_channel import alarm_pkg::*; (
   // Clock and control
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic tick,
   input wire logic accept,
   // Settings and value
   input wire alm_cfg_t cfg,
   input wire logic [13:0] value,
   // State
   output logic active,
   output logic alarm
);
   typedef struct packed {
      logic cond;
      logic act;
      logic muted;
      logic [11:0] wcnt;
      logic [11:0] mcnt;
   } chan_t;
   chan_t q, d;
   logic [14:0] v, t, h;
   logic [11:0] dly, mute;
   // Binary views of the settings
   assign v = {1'b0, value};
   assign t = {1'b0, bcd2bin(cfg.thr)};
   assign h = {1'b0, bcd2bin(cfg.hyst)};
   assign dly = sec_of(cfg.dly);
   assign mute = sec_of(cfg.mute);
   // ==========================================================
   // Next state
   always_comb begin
      d = q;
      // Sums kept at 15 bits so the band cannot wrap
      if (!cfg.en) begin
         d.cond = 1'b0;
      end else if (cfg.high) begin
         if (v >= t) d.cond = 1'b1;
         else if (v + h < t) d.cond = 1'b0;
      end else begin
         if (v <= t) d.cond = 1'b1;
         else if (v > t + h) d.cond = 1'b0;
      end
      // Activation wait counts whole ticks of a steady condition
      if (!d.cond) begin
         d.act = 1'b0;
         d.wcnt = '0;
         d.muted = 1'b0;
         d.mcnt = '0;
      end else if (!q.act) begin
         if (d.wcnt >= dly) d.act = 1'b1;
         else if (tick) d.wcnt = q.wcnt + 12'h001;
      end
      // Mute time runs down on the tick
      if (q.muted && tick) begin
         d.mcnt = q.mcnt - 12'h001;
         if (q.mcnt == 12'h001) d.muted = 1'b0;
      end
      if (accept && d.act && mute != '0) begin
         d.muted = 1'b1;
         d.mcnt = mute;
      end
   end
   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
   assign active = q.act;
   assign alarm = q.act & ~q.muted;
endmodule : alarm_channel
`default_nettype wire

// ==== test/panel_model.sv ====
// Front panel button model: presses and releases the four push-buttons.
// Assumes the panel samples pins through its own synchroniser.
`timescale 1ns/10ps
`default_nettype none
module panel_model import alarm_pkg::*; (
   // Clock
   input wire logic clk,
   // Button pins, active high
   output var btn_t btn
);
   // ==========================================
   // Pins released
   initial begin
      btn = 4'h0;
   end
   // Up goes down first so program lands on a held up
   task automatic press(input btn_t b);
      if (b.p && b.up) begin
         @(posedge clk);
         btn <= 4'h4;
         repeat (5) @(posedge clk);
      end
      @(posedge clk);
      btn <= b;
      repeat (6) @(posedge clk);
      btn <= 4'h0;
      repeat (6) @(posedge clk);
   endtask : press
endmodule : panel_model
`default_nettype wire

// ==== test/alarm_panel_asserts.sv ====
// Checks on the button menu and the alarm display outputs.
// Assumes it is bound to alarm_panel; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module alarm_panel_asserts import alarm_pkg::*; #(
   parameter int TICK_LEN = 20
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_B,
   // Watched ports
   input wire btn_t BTN,
   input wire logic [1:0] ALARM_IND,
   input wire logic SHOW_ALARM_ID,
   input wire menu_t MENU_STATE,
   input wire logic [1:0] EDIT_DIGIT,
   input wire logic DIGIT_FLASH
);
   // ==========================================
   // Idle counter, cleared by any pin change
   logic [31:0] idle_q;
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         idle_q <= 32'h0000_0000;
      end else if (MENU_STATE == M_DISP || $changed(BTN)) begin
         idle_q <= 32'h0000_0000;
      end else begin
         idle_q <= idle_q + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   // ==========================================
   // Menu transitions
   disp_exit_a: assert property (MENU_STATE == M_DISP |=>
      MENU_STATE inside {M_DISP, M_CODE, M_SP}) else $error("bad move from display");
   code_exit_a: assert property (MENU_STATE == M_CODE |=>
      MENU_STATE inside {M_CODE, M_CODE_ED, M_DISP}) else $error("bad move from code");
   code_edit_exit_a: assert property (MENU_STATE == M_CODE_ED |=>
      MENU_STATE inside {M_CODE_ED, M_SP, M_DISP}) else $error("bad code exit");
   sp_edit_exit_a: assert property (MENU_STATE == M_SP_ED |=>
      MENU_STATE inside {M_SP_ED, M_SP, M_DISP}) else $error("bad edit exit");
   idle_exit_a: assert property (idle_q <= 32'(11 * TICK_LEN + 10))
      else $error("menu outlived idle limit");
   // Digit editing
   digit_step_a: assert property ((MENU_STATE inside {M_CODE_ED, M_SP_ED})
      && $past(MENU_STATE) == MENU_STATE && $changed(EDIT_DIGIT)
      |-> EDIT_DIGIT == $past(EDIT_DIGIT) + 2'h1) else $error("digit skipped");
   flash_idle_a: assert property ((!(MENU_STATE inside {M_CODE_ED, M_SP_ED}))[*2]
      |-> !DIGIT_FLASH) else $error("flash outside edit");
   // Alarm identity on the display
   id_idle_a: assert property ((ALARM_IND == 2'h0)[*3] |-> !SHOW_ALARM_ID)
      else $error("alarm id without alarm");
   // Only a phase flip starts the count; a fresh alarm may meet a flip at once
   id_blink_a: assert property ($changed(SHOW_ALARM_ID) && ALARM_IND != 2'h0
      && $past(ALARM_IND) != 2'h0
      |=> ($stable(SHOW_ALARM_ID) || ALARM_IND == 2'h0 || $past(ALARM_IND) == 2'h0)[*8])
      else $error("alarm id toggles too fast");
   // Main scenarios
   cover property (MENU_STATE == M_SP_ED);
   cover property (MENU_STATE == M_CODE_ED ##1 MENU_STATE == M_SP);
   cover property (ALARM_IND[0] && SHOW_ALARM_ID);
endmodule : alarm_panel_asserts
bind alarm_panel alarm_panel_asserts #(.TICK_LEN(TICK_LEN)) u_chk (
   .CLK_SYS(CLK_SYS), .RST_B(RST_B), .BTN(BTN), .ALARM_IND(ALARM_IND),
   .SHOW_ALARM_ID(SHOW_ALARM_ID), .MENU_STATE(MENU_STATE), .EDIT_DIGIT(EDIT_DIGIT),
   .DIGIT_FLASH(DIGIT_FLASH)
);
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for alarm_panel: AHB-Lite tasks, button presses, values.
// Assumes a one second tick of TL cycles and the panel model on the pins.
`timescale 1ns/10ps
`default_nettype none
module tb import alarm_pkg::*; ;
   localparam int TL = 20;
   localparam btn_t B_P = 4'h8;
   localparam btn_t B_UP = 4'h4;
   localparam btn_t B_EX = 4'h1;
   localparam btn_t B_PU = 4'hC;
   logic clk_sys, rst_b, hsel, hwrite, hreadyout, hresp, show_id, flash, sp_sel;
   logic [1:0] htrans, alarm_sw, alarm_ind, edit_digit;
   logic [31:0] haddr, hwdata, hrdata, rd;
   bcd_t disp, edit_value;
   btn_t btn;
   menu_t menu;
   int miscompares, comparisons;
   bcd_t hv [5] = '{16'h0239, 16'h0240, 16'h0231, 16'h0230, 16'h0229};
   logic [2:0] he [5] = '{3'h2, 3'h7, 3'h7, 3'h7, 3'h2};
   // ==========================================
   // Design and panel
   alarm_panel #(.TICK_LEN(TL)) u_dut (
      .CLK_SYS(clk_sys), .RST_B(rst_b), .CE(1'h1), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
      .DISP_VALUE(disp), .BTN(btn), .ALARM_SW(alarm_sw), .ALARM_IND(alarm_ind),
      .SHOW_ALARM_ID(show_id), .MENU_STATE(menu), .EDIT_VALUE(edit_value),
      .EDIT_DIGIT(edit_digit), .DIGIT_FLASH(flash), .SP_SEL(sp_sel));
   panel_model u_panel (.clk(clk_sys), .btn(btn));
   // 20 MHz clock
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   // ==========================================
   // Tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wrap_up();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for a sampled ready
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'h1 && n < 100);
      if (n >= 100) begin
         miscompares++;
         wrap_up();
      end
   endtask : wait_rdy
   // One single word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      wait_rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rchk
   task automatic push(input btn_t b, input menu_t m);
      u_panel.press(b);
      chk(32'(menu), 32'(m));
   endtask : push
   task automatic at(input bcd_t v, input logic [2:0] e);
      disp <= v;
      cyc(5);
      chk(32'({alarm_ind[0], alarm_sw}), 32'(e));
   endtask : at
   // Hang guard
   initial begin
      cyc(20000);
      miscompares++;
      wrap_up();
   end
   // ==========================================
   // Main sequence
   initial begin
      miscompares = 0;
      comparisons = 0;
      {rst_b, hsel, hwrite, htrans} = 5'h00;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      disp = 16'h0000;
      cyc(2);
      rst_b <= 1'h1;
      // Delivery state and an unmapped place
      rchk(A_CTRL, 32'h0000_0000);
      rchk(A_PIN, 32'h0000_0000);
      rchk(8'h30, 32'h0000_0000);
      push(B_PU, M_DISP);
      // No passcode: straight to the threshold prompts
      bus(1'h1, A_CTRL, 32'h0000_0001);
      push(B_PU, M_SP);
      u_panel.press(B_UP);
      chk(32'(sp_sel), 32'h0000_0001);
      u_panel.press(B_UP);
      push(B_P, M_SP_ED);
      u_panel.press(B_UP);
      u_panel.press(B_P);
      u_panel.press(B_UP);
      chk(32'(edit_value), 32'h0000_1100);
      push(B_EX, M_SP);
      rchk(8'h10, 32'h0000_1100);
      push(B_EX, M_DISP);
      // Wrong code leaves; right code opens; idle time closes
      bus(1'h1, A_PIN, 32'h0000_1234);
      push(B_PU, M_CODE);
      u_panel.press(B_P);
      push(B_EX, M_DISP);
      u_panel.press(B_PU);
      push(B_P, M_CODE_ED);
      for (int d = 0; d < 4; d++) begin
         repeat (d + 1) u_panel.press(B_UP);
         u_panel.press(B_P);
      end
      chk(32'(edit_value), 32'h0000_1234);
      chk(32'(edit_digit), 32'h0000_0000);
      push(B_EX, M_SP);
      cyc(11 * TL);
      chk(32'(menu), 32'(M_DISP));
      // High alarm 240, band 10, no wait, closed in alarm
      bus(1'h1, 8'h10, 32'h0000_0240);
      bus(1'h1, 8'h14, 32'h0000_0010);
      bus(1'h1, A_CTRL, 32'h0000_002B);
      foreach (hv[i]) at(hv[i], he[i]);
      at(16'h0245, 3'h7);
      u_panel.press(B_P);
      chk(32'(alarm_sw), 32'h0000_0003);
      // Accept with a two second mute
      bus(1'h1, 8'h1C, 32'h0000_0002);
      u_panel.press(B_P);
      chk(32'({alarm_ind[0], alarm_sw}), 32'h0000_0006);
      cyc(2 * TL);
      chk(32'({alarm_ind[0], alarm_sw}), 32'h0000_0007);
      // Low alarm, open in alarm, then disabled
      bus(1'h1, 8'h1C, 32'h0000_0000);
      bus(1'h1, A_CTRL, 32'h0000_0003);
      at(16'h0240, 3'h6);
      at(16'h0250, 3'h6);
      at(16'h0251, 3'h3);
      bus(1'h1, A_CTRL, 32'h0000_0001);
      at(16'h0200, 3'h3);
      rchk(8'h10, 32'h0000_0240);
      // Three second wait restarted by a dropout
      bus(1'h1, 8'h18, 32'h0000_0003);
      bus(1'h1, A_CTRL, 32'h0000_002B);
      disp <= 16'h0250;
      cyc(30);
      chk(32'(alarm_ind), 32'h0000_0000);
      disp <= 16'h0200;
      cyc(10);
      disp <= 16'h0250;
      cyc(30);
      chk(32'(alarm_ind), 32'h0000_0000);
      cyc(40);
      chk(32'({alarm_ind[0], alarm_sw}), 32'h0000_0007);
      rchk(A_STAT, 32'h0000_001D);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
